// ==== logic/pps_cfg.svh ====
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH
// Register map, byte addresses on the bus
`define PPS_IN_BASE 8'h00
`define PPS_OUT_BASE 8'h40
`define PPS_OSC_OFS 8'h80
`define PPS_STS_OFS 8'h84
`define PPS_MSK_OFS 8'h88
`define PPS_N_IN_REG 14
`define PPS_N_OUT_REG 13
// Field layout inside a map word and the oscillator control word
`define PPS_HI_LSB 8
`define PPS_LOCK_BIT 6
// Unlock keys
`define PPS_KEY1 8'h46
`define PPS_KEY2 8'h57
// Select codes
`define PPS_SEL_GND 5'h1f
`define PPS_SEL_NULL 5'h00
`define PPS_CODE_CMP1 5'h01
`define PPS_CODE_SS2 5'h0c
`define PPS_CODE_CAN 5'h10
`define PPS_CODE_OC1 5'h12
`define PPS_CODE_OC4 5'h15
// Event bits of status and mask
`define PPS_N_EV 3
`define PPS_EV_LOCKED 0
`define PPS_EV_MISM 1
`define PPS_EV_ABORT 2
`endif

// ==== logic/pps_pkg.sv ====
`default_nettype none
package pps_pkg;
  typedef logic [4:0] pps_sel_t;
  typedef enum logic [1:0] {
    PPS_K_IDLE = 2'b00,
    PPS_K_ONE = 2'b01,
    PPS_K_OPEN = 2'b11
  } pps_key_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } pps_wb_req_t;
endpackage : pps_pkg
`default_nettype wire

// ==== logic/pps_lock.sv ====
`default_nettype none
`include "pps_cfg.svh"
module pps_lock #(
  parameter int N_IN_REG = `PPS_N_IN_REG,
  parameter int N_OUT_REG = `PPS_N_OUT_REG,
  parameter int N_CODE = 22
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Wishbone slave
  input wire pps_pkg::pps_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Remappable pins
  input wire logic [2*N_OUT_REG-1:0] remappable_pin_in,
  output logic [2*N_OUT_REG-1:0] remappable_pin_out,
  output logic [2*N_OUT_REG-1:0] remappable_pin_own,
  // Peripheral side
  input wire logic [N_CODE-1:0] periph_out,
  output logic [2*N_IN_REG-1:0] periph_in,
  // Configuration and status
  input wire logic one_session_lock_cfg,
  output logic map_lock_flag,
  output logic config_mismatch_rst,
  output logic irq
);
  localparam int N_INF = 2 * N_IN_REG;
  localparam int N_PIN = 2 * N_OUT_REG;
  localparam logic [5:0] IN_W = 6'(`PPS_IN_BASE >> 2);
  localparam logic [5:0] OUT_W = 6'(`PPS_OUT_BASE >> 2);

  typedef struct packed {
    logic [N_INF-1:0][4:0] in_sel;
    logic [N_PIN-1:0][4:0] out_sel;
    logic [N_INF-1:0][4:0] in_shd;
    logic [N_PIN-1:0][4:0] out_shd;
    logic lock;
    pps_pkg::pps_key_t key;
    logic [`PPS_N_EV-1:0] sts;
    logic [`PPS_N_EV-1:0] msk;
    logic ack;
    logic [31:0] rdat;
    logic [N_PIN-1:0] pin_s1;
    logic [N_PIN-1:0] pin_s2;
    logic cfg_s1;
    logic cfg_s2;
    logic [N_INF-1:0] pin_in;
    logic [N_PIN-1:0] pout;
    logic [N_PIN-1:0] pown;
    logic mism;
  } pps_state_t;

  pps_state_t st_reg;
  pps_state_t st_next;

  // Valid peripheral output codes; the gaps drive nothing
  function automatic logic pps_code_ok(input pps_pkg::pps_sel_t c);
    return (c >= `PPS_CODE_CMP1 && c <= `PPS_CODE_SS2) ||
      c == `PPS_CODE_CAN ||
      (c >= `PPS_CODE_OC1 && c <= `PPS_CODE_OC4);
  endfunction : pps_code_ok

  logic req;
  logic wr;
  logic [5:0] widx;
  logic [5:0] in_i;
  logic [5:0] out_i;
  logic in_hit;
  logic out_hit;
  logic osc_hit;
  logic sts_hit;
  logic msk_hit;
  logic [`PPS_N_EV-1:0] ev;
  logic [`PPS_N_EV-1:0] clr;

  // One request per ack; the master drops stb after it
  assign req = wb_req.cyc & wb_req.stb & ~st_reg.ack;
  assign wr = req & wb_req.we;
  assign widx = wb_req.adr[7:2];
  assign in_i = widx - IN_W;
  assign out_i = widx - OUT_W;
  assign in_hit = widx >= IN_W && widx < IN_W + 6'(N_IN_REG);
  assign out_hit = widx >= OUT_W && widx < OUT_W + 6'(N_OUT_REG);
  assign osc_hit = wb_req.adr == `PPS_OSC_OFS;
  assign sts_hit = wb_req.adr == `PPS_STS_OFS;
  assign msk_hit = wb_req.adr == `PPS_MSK_OFS;

  always_comb begin
    st_next = st_reg;
    ev = '0;
    clr = '0;
    st_next.ack = req;
    // Pins are asynchronous to ref_clk
    st_next.pin_s1 = remappable_pin_in;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.cfg_s1 = one_session_lock_cfg;
    st_next.cfg_s2 = st_reg.cfg_s1;

    // Input map writes, two fields per word
    for (int f = 0; f < N_INF; f++) begin
      if (wr && in_hit && in_i == 6'(f / 2) && wb_req.sel[f % 2]) begin
        if (st_reg.lock) begin
          ev[`PPS_EV_LOCKED] = 1'b1;
        end else begin
          st_next.in_sel[f] = wb_req.dat[(f % 2) * `PPS_HI_LSB +: 5];
          st_next.in_shd[f] = wb_req.dat[(f % 2) * `PPS_HI_LSB +: 5];
        end
      end
    end

    // Output map writes, kept apart from the input map
    for (int p = 0; p < N_PIN; p++) begin
      if (wr && out_hit && out_i == 6'(p / 2) && wb_req.sel[p % 2]) begin
        if (st_reg.lock) begin
          ev[`PPS_EV_LOCKED] = 1'b1;
        end else begin
          st_next.out_sel[p] = wb_req.dat[(p % 2) * `PPS_HI_LSB +: 5];
          st_next.out_shd[p] = wb_req.dat[(p % 2) * `PPS_HI_LSB +: 5];
        end
      end
    end

    // Key sequence on the low byte of the oscillator control word
    if (wr && osc_hit && wb_req.sel[0]) begin
      unique case (st_reg.key)
        pps_pkg::PPS_K_IDLE: begin
          if (wb_req.dat[7:0] == `PPS_KEY1) begin
            st_next.key = pps_pkg::PPS_K_ONE;
          end
        end
        pps_pkg::PPS_K_ONE: begin
          if (wb_req.dat[7:0] == `PPS_KEY2) begin
            st_next.key = pps_pkg::PPS_K_OPEN;
          end else begin
            st_next.key = pps_pkg::PPS_K_IDLE;
            ev[`PPS_EV_ABORT] = 1'b1;
          end
        end
        pps_pkg::PPS_K_OPEN: begin
          st_next.key = pps_pkg::PPS_K_IDLE;
          // Set lock stays set until reset in one-session mode
          if (!(st_reg.cfg_s2 && st_reg.lock)) begin
            st_next.lock = wb_req.dat[`PPS_LOCK_BIT];
          end
        end
        default: begin
          st_next.key = pps_pkg::PPS_K_IDLE;
        end
      endcase
    end else if (wr && st_reg.key != pps_pkg::PPS_K_IDLE) begin
      st_next.key = pps_pkg::PPS_K_IDLE;
      ev[`PPS_EV_ABORT] = 1'b1;
    end

    // Shadow comparison, no bus path can make the copies differ
    st_next.mism = st_reg.in_sel != st_reg.in_shd ||
      st_reg.out_sel != st_reg.out_shd;
    ev[`PPS_EV_MISM] = st_reg.mism;

    // Status is write one to clear; a new event wins over the clear
    if (wr && sts_hit && wb_req.sel[0]) begin
      clr = wb_req.dat[`PPS_N_EV-1:0];
    end
    st_next.sts = (st_reg.sts & ~clr) | ev;
    if (wr && msk_hit && wb_req.sel[0]) begin
      st_next.msk = wb_req.dat[`PPS_N_EV-1:0];
    end

    // Read data; unmapped reads answer zero
    st_next.rdat = '0;
    if (req && !wb_req.we) begin
      if (in_hit) begin
        st_next.rdat[`PPS_HI_LSB +: 5] = st_reg.in_sel[{in_i[4:0], 1'b1}];
        st_next.rdat[4:0] = st_reg.in_sel[{in_i[4:0], 1'b0}];
      end else if (out_hit) begin
        st_next.rdat[`PPS_HI_LSB +: 5] = st_reg.out_sel[{out_i[4:0], 1'b1}];
        st_next.rdat[4:0] = st_reg.out_sel[{out_i[4:0], 1'b0}];
      end else if (osc_hit) begin
        st_next.rdat[`PPS_LOCK_BIT] = st_reg.lock;
      end else if (sts_hit) begin
        st_next.rdat[`PPS_N_EV-1:0] = st_reg.sts;
      end else if (msk_hit) begin
        st_next.rdat[`PPS_N_EV-1:0] = st_reg.msk;
      end
    end

    // Input routing from synchronised pins
    for (int f = 0; f < N_INF; f++) begin
      if (st_reg.in_sel[f] < 5'(N_PIN)) begin
        st_next.pin_in[f] = st_reg.pin_s2[st_reg.in_sel[f]];
      end else begin
        st_next.pin_in[f] = 1'b0;
      end
    end

    // Output routing; unknown codes behave as null
    for (int p = 0; p < N_PIN; p++) begin
      if (pps_code_ok(st_reg.out_sel[p])) begin
        st_next.pout[p] = periph_out[st_reg.out_sel[p]];
        st_next.pown[p] = 1'b1;
      end else begin
        st_next.pout[p] = 1'b0;
        st_next.pown[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.in_sel <= {N_INF{`PPS_SEL_GND}};
      st_reg.in_shd <= {N_INF{`PPS_SEL_GND}};
      st_reg.out_sel <= {N_PIN{`PPS_SEL_NULL}};
      st_reg.out_shd <= {N_PIN{`PPS_SEL_NULL}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = st_reg.rdat;
  assign wb_ack_o = st_reg.ack;
  assign periph_in = st_reg.pin_in;
  assign remappable_pin_out = st_reg.pout;
  assign remappable_pin_own = st_reg.pown;
  assign map_lock_flag = st_reg.lock;
  assign config_mismatch_rst = st_reg.mism;
  assign irq = |(st_reg.sts & st_reg.msk);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_in_route: assert property (
    st_reg.in_sel[0] < 5'(N_PIN) |=> periph_in[0] == $past(st_reg.pin_s2[st_reg.in_sel[0]]))
    else $error("input field does not follow its pin");
  a_in_tie: assert property (
    st_reg.in_sel[0] >= 5'(N_PIN) |=> !periph_in[0])
    else $error("out of range input select not tied low");
  a_out_cmp: assert property (
    st_reg.out_sel[0] == `PPS_CODE_CMP1 |=> remappable_pin_out[0] == $past(periph_out[1]))
    else $error("comparator code not routed");
  a_null_code: assert property (
    st_reg.out_sel[0] == `PPS_SEL_NULL |=> !remappable_pin_own[0] && !remappable_pin_out[0])
    else $error("null code still owns the pin");
  a_can_code: assert property (
    st_reg.out_sel[1] == `PPS_CODE_CAN |=> remappable_pin_own[1])
    else $error("transmit code does not own the pin");
  a_locked_map: assert property (
    st_reg.lock && wr && (in_hit || out_hit) |=> $stable(st_reg.in_sel) && $stable(st_reg.out_sel)
      ##0 wb_ack_o)
    else $error("locked map write changed the map");
  a_lock_gate: assert property (
    $changed(st_reg.lock) |-> $past(st_reg.key) == pps_pkg::PPS_K_OPEN)
    else $error("lock changed without the key sequence");
  a_lock_holds: assert property (
    st_reg.key != pps_pkg::PPS_K_OPEN ##1 st_reg.key != pps_pkg::PPS_K_OPEN
      |=> $stable(st_reg.lock)[*2])
    else $error("lock drifted outside a session");
  a_one_way: assert property (
    st_reg.cfg_s2 && st_reg.lock |=> st_reg.lock)
    else $error("one session lock was cleared");
  a_key_abort: assert property (
    st_reg.key == pps_pkg::PPS_K_ONE && wr && !osc_hit |=> st_reg.key == pps_pkg::PPS_K_IDLE
      && st_reg.sts[`PPS_EV_ABORT])
    else $error("broken key sequence not aborted");
  a_shadow_trip: assert property (
    st_reg.in_sel != st_reg.in_shd |=> config_mismatch_rst ##1 st_reg.sts[`PPS_EV_MISM])
    else $error("shadow mismatch not reported");
  a_reset_map: assert property (
    $past(rst) |-> st_reg.out_sel[0] == `PPS_SEL_NULL && st_reg.in_sel[0] == `PPS_SEL_GND)
    else $error("map not at reset values");

  // Bus answer
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows: assert property (
    wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  a_rdat_idle: assert property (
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside ack");
  a_lock_read: assert property (
    req && !wb_req.we && osc_hit |=> wb_dat_o[`PPS_LOCK_BIT] == $past(st_reg.lock))
    else $error("lock flag not readable");
  a_unmapped_rd: assert property (
    req && !wb_req.we && !(in_hit || out_hit || osc_hit || sts_hit || msk_hit)
      |=> wb_dat_o == '0)
    else $error("unmapped read not zero");
  // Status and mask; a new event must win over a clear
  a_sts_set: assert property (
    ev[`PPS_EV_LOCKED] |=> st_reg.sts[`PPS_EV_LOCKED])
    else $error("locked write event lost");
  a_sts_clear: assert property (
    wr && sts_hit && wb_req.sel[0] && wb_req.dat[`PPS_EV_ABORT] && !ev[`PPS_EV_ABORT]
      |=> !st_reg.sts[`PPS_EV_ABORT])
    else $error("status bit not cleared");
  a_mask_write: assert property (
    wr && msk_hit && wb_req.sel[0] |=> st_reg.msk == $past(wb_req.dat[`PPS_N_EV-1:0]))
    else $error("mask write lost");
  // Routing
  a_in_high: assert property (
    st_reg.in_sel[1] < 5'(N_PIN) |=> periph_in[1] == $past(st_reg.pin_s2[st_reg.in_sel[1]]))
    else $error("high input field does not follow its pin");
  a_oc_code: assert property (
    st_reg.out_sel[0] == `PPS_CODE_OC4
      |=> remappable_pin_own[0] && remappable_pin_out[0] == $past(periph_out[`PPS_CODE_OC4]))
    else $error("compare channel code not routed");
  a_gap_code: assert property (
    st_reg.out_sel[0] > `PPS_CODE_SS2 && st_reg.out_sel[0] < `PPS_CODE_CAN
      |=> !remappable_pin_own[0])
    else $error("unused code owns the pin");
  a_top_code: assert property (
    st_reg.out_sel[1] > `PPS_CODE_OC4 |=> !remappable_pin_own[1])
    else $error("code above the table owns the pin");
  // Map writes and lock
  a_in_write: assert property (
    !st_reg.lock && wr && in_hit && wb_req.sel[0]
      |=> st_reg.in_sel[$past({in_i[4:0], 1'b0})] == $past(wb_req.dat[4:0]))
    else $error("unlocked input write lost");
  a_out_write: assert property (
    !st_reg.lock && wr && out_hit && wb_req.sel[0]
      |=> st_reg.out_sel[$past({out_i[4:0], 1'b0})] == $past(wb_req.dat[4:0]))
    else $error("unlocked output write lost");
  a_locked_event: assert property (
    st_reg.lock && wr && (in_hit || out_hit) && wb_req.sel[0] |=> st_reg.sts[`PPS_EV_LOCKED])
    else $error("locked write not flagged");
  a_key_first: assert property (
    wr && osc_hit && wb_req.sel[0] && st_reg.key == pps_pkg::PPS_K_IDLE
      && wb_req.dat[7:0] == `PPS_KEY1 |=> st_reg.key == pps_pkg::PPS_K_ONE)
    else $error("first key not taken");
  a_key_second: assert property (
    wr && osc_hit && wb_req.sel[0] && st_reg.key == pps_pkg::PPS_K_ONE
      && wb_req.dat[7:0] == `PPS_KEY2 |=> st_reg.key == pps_pkg::PPS_K_OPEN)
    else $error("second key not taken");
  a_key_close: assert property (
    st_reg.key == pps_pkg::PPS_K_OPEN && wr |=> st_reg.key == pps_pkg::PPS_K_IDLE)
    else $error("unlock window left open");
  a_lock_set: assert property (
    st_reg.key == pps_pkg::PPS_K_OPEN && wr && osc_hit && wb_req.sel[0]
      && wb_req.dat[`PPS_LOCK_BIT] |=> map_lock_flag)
    else $error("lock not set by the session");
  a_lock_clear: assert property (
    st_reg.key == pps_pkg::PPS_K_OPEN && wr && osc_hit && wb_req.sel[0]
      && !wb_req.dat[`PPS_LOCK_BIT] && !st_reg.cfg_s2 |=> !map_lock_flag)
    else $error("lock not cleared in open mode");
  // Shadow and reset
  a_out_shadow: assert property (
    st_reg.out_sel != st_reg.out_shd |=> config_mismatch_rst)
    else $error("output shadow mismatch not reported");
  a_no_mismatch: assert property (
    st_reg.in_sel == st_reg.in_shd && st_reg.out_sel == st_reg.out_shd
      |=> !config_mismatch_rst)
    else $error("mismatch reset without a difference");
  a_reset_outs: assert property (
    $past(rst) |-> remappable_pin_own == '0 && periph_in == '0 && !map_lock_flag && !irq)
    else $error("outputs not at reset values");

  c_unlock: cover property (st_reg.key == pps_pkg::PPS_K_OPEN);
  c_relock: cover property (!st_reg.lock ##1 st_reg.lock);
  c_locked_try: cover property (st_reg.sts[`PPS_EV_LOCKED]);
  c_pin_owned: cover property (remappable_pin_own[0]);
  c_one_way: cover property (st_reg.cfg_s2 && st_reg.lock && st_reg.key == pps_pkg::PPS_K_OPEN);
endmodule : pps_lock
`default_nettype wire

// ==== testbench/rpsl_far_model.sv ====
`default_nettype none
module rpsl_far_model (
  // Clock
  input wire logic ref_clk,
  // Bench control
  input wire logic [4:0] drive_code,
  input wire logic level,
  input wire logic [25:0] pin_lvl,
  // Towards the block
  output logic [21:0] periph_out,
  output logic [25:0] remappable_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Others carry the inverse, so a wrong mux pick shows
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 22; i++) begin
      periph_out[i] <= (i == int'(drive_code)) ? level : ~level;
    end
    remappable_pin_in <= pin_lvl;
  end
endmodule : rpsl_far_model
`default_nettype wire

// ==== testbench/remappable_pin_select_lock_tb.sv ====
`default_nettype none
module remappable_pin_select_lock_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  pps_pkg::pps_wb_req_t wb_req = '0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_ack_o;
  logic [25:0] pin_in;
  logic [25:0] pin_out;
  logic [25:0] pin_own;
  logic [25:0] pin_lvl = '1;
  logic [21:0] periph_out;
  logic [27:0] periph_in;
  logic cfg = 1'b0;
  logic lock;
  logic mism;
  logic irq;
  logic [4:0] drive_code = '0;
  logic level = 1'b1;
  int mismatches = 0;
  int samples_checked = 0;
  // Own flag beside output code
  logic [5:0] rows [0:22] = '{6'h00, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27,
    6'h28, 6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h0d, 6'h0e, 6'h0f, 6'h30, 6'h11, 6'h32,
    6'h33, 6'h34, 6'h35, 6'h1f};

  always #20 ref_clk = ~ref_clk;

  pps_lock i_pps_lock (.ref_clk(ref_clk), .rst(rst), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .remappable_pin_in(pin_in), .remappable_pin_out(pin_out),
    .remappable_pin_own(pin_own), .periph_out(periph_out), .periph_in(periph_in),
    .one_session_lock_cfg(cfg), .map_lock_flag(lock), .config_mismatch_rst(mism), .irq(irq));

  rpsl_far_model i_rpsl_far_model (.ref_clk(ref_clk), .drive_code(drive_code), .level(level),
    .pin_lvl(pin_lvl), .periph_out(periph_out), .remappable_pin_in(pin_in));

  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Ends at the falling edge so later checks see settled values
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      mismatches++;
      close_out();
    end
    rd = wb_dat_o;
    wb_req <= '0;
    @(negedge ref_clk);
    if (wb_ack_o !== 1'b0) begin
      mismatches++;
      close_out();
    end
  endtask : bus

  task automatic key(input logic [7:0] v);
    bus(1'b1, 8'h80, 32'h46);
    bus(1'b1, 8'h80, 32'h57);
    bus(1'b1, 8'h80, {24'h0, v});
  endtask : key

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, 8'h00, '0);
    chk(rd, 32'h1f1f);
    bus(1'b0, 8'h70, '0);
    chk(rd, 32'h0);
    chk(32'({pin_own, irq, lock, mism}), '0);
    chk(32'(periph_in), '0);
    foreach (rows[i]) begin
      drive_code <= rows[i][4:0];
      bus(1'b1, 8'h40, {19'h0, rows[i][4:0], 3'h0, rows[i][4:0]});
      repeat (3) @(negedge ref_clk);
      chk(32'({pin_own[1:0], pin_out[1:0] | {2{~rows[i][5]}}}),
        {28'h0, {2{rows[i][5]}}, 2'b11});
    end
    // Last output word, low level
    drive_code <= 5'h01;
    level <= 1'b0;
    bus(1'b1, 8'h70, 32'h0100);
    repeat (3) @(negedge ref_clk);
    chk(32'({pin_own[25], pin_out[25]}), 32'h2);
    pin_lvl <= 26'h2000008;
    bus(1'b1, 8'h34, 32'h1903);
    repeat (6) @(negedge ref_clk);
    chk(32'(periph_in), 32'h0c000000);
    pin_lvl <= 26'h0000001;
    bus(1'b1, 8'h34, 32'h1a00);
    repeat (6) @(negedge ref_clk);
    chk(32'(periph_in[27:26]), 32'h1);
    bus(1'b0, 8'hc0, '0);
    chk(rd, '0);
    key(8'h40);
    chk(32'(lock), 32'h1);
    bus(1'b0, 8'h80, '0);
    chk(rd, 32'h40);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b0, 8'h00, '0);
    chk(rd, 32'h1f1f);
    chk(32'(irq), '0);
    bus(1'b1, 8'h88, 32'h1);
    chk(32'(irq), 32'h1);
    bus(1'b1, 8'h84, 32'h1);
    chk(32'(irq), '0);
    // Broken key pair must not unlock
    bus(1'b1, 8'h80, 32'h46);
    bus(1'b1, 8'h88, 32'h4);
    bus(1'b1, 8'h80, 32'h57);
    bus(1'b1, 8'h80, 32'h00);
    chk(32'({lock, irq}), 32'h3);
    bus(1'b0, 8'h84, '0);
    chk(rd, 32'h4);
    key(8'h00);
    chk(32'(lock), '0);
    bus(1'b1, 8'h04, 32'h0502);
    bus(1'b1, 8'h08, 32'h0304);
    bus(1'b0, 8'h04, '0);
    chk(rd, 32'h0502);
    bus(1'b0, 8'h08, '0);
    chk(rd, 32'h0304);
    key(8'h40);
    key(8'h00);
    chk(32'(lock), '0);
    @(posedge ref_clk);
    cfg <= 1'b1;
    repeat (4) @(negedge ref_clk);
    key(8'h40);
    key(8'h00);
    chk(32'(lock), 32'h1);
    chk(32'(mism), '0);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk(32'(lock), '0);
    close_out();
  end
endmodule : remappable_pin_select_lock_tb
`default_nettype wire
